// File: verification/omsp_ext_mem.sv
`timescale 1ns/1ns
module omsp_ext_mem (
  input wire logic clk_sys,
  input wire logic ext_req,
  input wire logic [15:0] ext_address,
  output logic [15:0] ext_readdata
);
  logic [15:0] last_q;
  // Released bus shows the inverse of the last driven value
  assign ext_readdata = ext_req ? ~ext_address : ~last_q;
  always_ff @(posedge clk_sys) begin
    if (ext_req) begin
      last_q <= ~ext_address;
    end
  end
endmodule // omsp_ext_mem

// File: verification/onchip_memory_select_prom_port_tb.sv
`timescale 1ns/1ns
module onchip_memory_select_prom_port_tb;
  logic clk_sys = 1'b0, nrst = 1'b0;
  logic [15:0] avs_address = 16'h0, avs_writedata = 16'h0, avs_readdata, ext_address;
  logic [15:0] ext_readdata, rd;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest, ext_req, xr;
  logic mode_select_pin_upper = 1'b1, mode_select_pin_lower = 1'b1;
  logic hardware_standby_pin = 1'b1, sw_standby = 1'b0;
  logic prom_select_pin_a = 1'b0, prom_select_pin_b = 1'b0;
  logic prom_ce_n = 1'b1, prom_oe_n = 1'b1, cpu_halt, rom_enabled, internal_ram_on_bit;
  logic [14:0] prom_address_pins = 15'h0;
  logic [7:0] prom_data_pins_i, prom_data_pins_o, prom_data_pins_oe, wdat = 8'h0;
  logic [4:0] rows [3] = '{5'h09, 5'h16, 5'h1f}; // mode pins, rom on, mode code
  logic [22:0] prows [4] = '{23'h0000a5, 23'h3fff5a, 23'h0001ff, 23'h4000ff}; // address, data
  logic [1:0] be = 2'h3;
  int bad_count = 0, checks_done = 0, st;
  always #50 clk_sys = ~clk_sys;
  assign prom_data_pins_i = (|prom_data_pins_oe) ? prom_data_pins_o : wdat;
  omsp_mem_select omsp_mem_select_inst (.clk_sys, .nrst, .avs_address, .avs_read,
    .avs_write, .avs_byteenable(be), .avs_writedata, .avs_readdata, .avs_waitrequest,
    .ext_req, .ext_address, .ext_readdata, .mode_select_pin_upper, .mode_select_pin_lower,
    .hardware_standby_pin, .prom_select_pin_a, .prom_select_pin_b, .sw_standby, .prom_ce_n,
    .prom_oe_n, .prom_address_pins, .prom_data_pins_i, .prom_data_pins_o,
    .prom_data_pins_oe, .cpu_halt, .rom_enabled, .internal_ram_on_bit);
  omsp_ext_mem omsp_ext_mem_inst (.clk_sys, .ext_req, .ext_address, .ext_readdata);
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] ad, input logic [15:0] d);
    @(posedge clk_sys);
    avs_address <= ad;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    st = 0;
    do begin
      @(posedge clk_sys);
      st++;
    end while (avs_waitrequest !== 1'b0 && st < 50);
    xr = ext_req;
    rd = avs_readdata;
    if (avs_waitrequest !== 1'b0) begin
      bad_count++;
      $display("[FAIL] %0t bus wait timed out", $time);
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rst(input logic [1:0] md, input logic sb, input logic sel);
    @(posedge clk_sys);
    {mode_select_pin_upper, mode_select_pin_lower} <= md;
    hardware_standby_pin <= sb;
    prom_select_pin_a <= sel;
    prom_select_pin_b <= sel;
    nrst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (5) @(posedge clk_sys);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #2000000;
    bad_count++;
    test_done();
  end
  initial begin
    for (int i = 0; i < 3; i++) begin
      rst(rows[i][4:3], 1'b1, 1'b0);
      chk(rom_enabled, rows[i][2]);
      chk(internal_ram_on_bit, 1'b1);
      acc(1'b0, omsp_pkg::MODE_OFS, 16'h0);
      chk(rd[1:0], rows[i][1:0]);
      acc(1'b0, 16'h0100, 16'h0);
      chk(xr, !rows[i][2]);
      chk(st, 16'h2);
      acc(1'b1, omsp_pkg::RAM_HI - 16'h1, 16'h5a00 + i);
      acc(1'b0, omsp_pkg::RAM_HI - 16'h1, 16'h0);
      chk(rd, 16'h5a00 + i);
      chk(xr, 1'b0);
      acc(1'b1, omsp_pkg::CTRL_OFS, 16'h0);
      chk(internal_ram_on_bit, 1'b0);
      acc(1'b1, omsp_pkg::RAM_HI - 16'h1, 16'h1234);
      acc(1'b0, omsp_pkg::RAM_HI - 16'h1, 16'h0);
      if (i == 2) begin
        chk(rd, {omsp_pkg::ERASED, omsp_pkg::ERASED});
        acc(1'b1, omsp_pkg::CTRL_OFS, 16'h1);
        acc(1'b0, omsp_pkg::RAM_HI - 16'h1, 16'h0);
        chk(rd, 16'h5a00 + i);
        sw_standby <= 1'b1;
        acc(1'b1, omsp_pkg::CTRL_OFS, 16'h0);
        chk(internal_ram_on_bit, 1'b1);
        sw_standby <= 1'b0;
        be <= 2'h1;
        acc(1'b1, omsp_pkg::RAM_HI, 16'h00c3);
        chk(st, 16'h2);
        be <= 2'h3;
        acc(1'b0, omsp_pkg::RAM_HI - 16'h1, 16'h0);
        chk(rd, 16'h5ac3);
      end else begin
        chk(rd, ~(omsp_pkg::RAM_HI - 16'h1));
        chk(xr, 1'b1);
      end
    end
    rst(2'h0, 1'b0, 1'b1);
    chk(cpu_halt, 1'b1);
    for (int j = 0; j < 4; j++) begin
      prom_address_pins <= prows[j][22:8];
      wdat <= prows[j][7:0];
      repeat (4) @(posedge clk_sys);
      prom_ce_n <= 1'b0;
      repeat (4) @(posedge clk_sys);
      prom_ce_n <= 1'b1;
      wdat <= ~prows[j][7:0];
      repeat (4) @(posedge clk_sys);
      prom_oe_n <= 1'b0;
      repeat (6) @(posedge clk_sys);
      chk(prom_data_pins_oe, 8'hff);
      chk(prom_data_pins_o, prows[j][7:0]);
      prom_oe_n <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk(prom_data_pins_oe, 8'h00);
    end
    test_done();
  end
endmodule // onchip_memory_select_prom_port_tb

// File: verilog/omsp_mem_select.sv
// Added by the designer: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
module omsp_mem_select (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [1:0] avs_byteenable,
  input wire logic [15:0] avs_writedata,
  output logic [15:0] avs_readdata,
  output logic avs_waitrequest,
  output logic ext_req,
  output logic [15:0] ext_address,
  input wire logic [15:0] ext_readdata,
  input wire logic mode_select_pin_upper,
  input wire logic mode_select_pin_lower,
  input wire logic hardware_standby_pin,
  input wire logic prom_select_pin_a,
  input wire logic prom_select_pin_b,
  input wire logic sw_standby,
  input wire logic prom_ce_n,
  input wire logic prom_oe_n,
  input wire logic [14:0] prom_address_pins,
  input wire logic [7:0] prom_data_pins_i,
  output logic [7:0] prom_data_pins_o,
  output logic [7:0] prom_data_pins_oe,
  output logic cpu_halt,
  output logic rom_enabled,
  output logic internal_ram_on_bit
);
  localparam int PIN_W = 5 + $bits(omsp_pkg::omsp_prom_in_t);

  logic [PIN_W-1:0] pins_raw, pins_s;
  omsp_pkg::omsp_prom_in_t prom_s;
  logic md1_s, md0_s, hardware_standby_pin_s, sel_a_s, sel_b_s;
  omsp_pkg::omsp_mode_t mode_q;
  logic caught_q;
  logic [1:0] rel_q;
  logic ram_on_q;
  logic [7:0] rom_q [omsp_pkg::ROM_BYTES];
  logic [7:0] ram_q [omsp_pkg::RAM_BYTES];
  logic [1:0] st_q;
  logic busy_q;
  logic prom_ce_n_d1_q;
  logic [7:0] prom_do_q;
  logic prom_mode;
  logic in_ram, in_rom, in_ctrl, in_mode, ram_int, ram_blocked, rom_int;
  logic done;
  logic [8:0] ram_idx;
  logic [13:0] rom_idx;
  logic [15:0] rd_d;

  assign pins_raw = {mode_select_pin_upper, mode_select_pin_lower, hardware_standby_pin,
                     prom_select_pin_a, prom_select_pin_b, prom_ce_n, prom_oe_n,
                     prom_address_pins, prom_data_pins_i};

  omsp_sync #(.W(PIN_W)) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .d(pins_raw),
    .q(pins_s)
  );

  assign {md1_s, md0_s, hardware_standby_pin_s, sel_a_s, sel_b_s} = pins_s[PIN_W-1 -: 5];
  assign prom_s = omsp_pkg::omsp_prom_in_t'(pins_s[PIN_W-6:0]);

  // Entry to programming mode
  assign prom_mode = !md1_s && !md0_s && !hardware_standby_pin_s && sel_a_s && sel_b_s;
  assign cpu_halt = prom_mode;

  // Mode caught once the synchroniser holds real pin values, not its reset zeros
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rel_q <= 2'h0;
      caught_q <= 1'b0;
      mode_q <= omsp_pkg::OMSP_MODE_3;
    end else begin
      rel_q <= {rel_q[0], 1'b1};
      if (rel_q[1] && !caught_q) begin
        caught_q <= 1'b1;
        mode_q <= omsp_pkg::omsp_mode_t'({md1_s, md0_s});
      end
    end
  end

  assign rom_enabled = (mode_q == omsp_pkg::OMSP_MODE_2) ||
                       (mode_q == omsp_pkg::OMSP_MODE_3);

  // Address decode
  always_comb begin
    in_ram = (avs_address >= omsp_pkg::RAM_LO) && (avs_address <= omsp_pkg::RAM_HI);
    in_rom = (avs_address <= omsp_pkg::ROM_HI);
    in_ctrl = (avs_address == omsp_pkg::CTRL_OFS);
    in_mode = (avs_address == omsp_pkg::MODE_OFS);
  end

  assign ram_int = in_ram && ram_on_q;
  assign ram_blocked = in_ram && !ram_on_q && (mode_q == omsp_pkg::OMSP_MODE_3);
  assign rom_int = in_rom && rom_enabled;
  assign ext_req = (avs_read || avs_write) && !cpu_halt && !ram_int && !ram_blocked &&
                   !rom_int && !in_ctrl && !in_mode;
  assign ext_address = avs_address;
  assign ram_idx = 9'(avs_address - omsp_pkg::RAM_LO);
  assign rom_idx = avs_address[13:0];

  // Two-state access timer
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= 2'h0;
      busy_q <= 1'b0;
    end else if (done) begin
      st_q <= 2'h0;
      busy_q <= 1'b0;
    end else if ((avs_read || avs_write) && !cpu_halt) begin
      st_q <= st_q + 2'h1;
      busy_q <= 1'b1;
    end
  end

  assign done = busy_q && (st_q == omsp_pkg::ACC_STATES - 2'h1);
  assign avs_waitrequest = !done;

  // RAM on bit: reset to one, untouched by software standby
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      ram_on_q <= omsp_pkg::RAM_ON_RST;
    end else if (done && avs_write && in_ctrl && avs_byteenable[0] && !sw_standby) begin
      ram_on_q <= avs_writedata[0];
    end
  end

  assign internal_ram_on_bit = ram_on_q;

  // Internal RAM storage
  always_ff @(posedge clk_sys) begin
    if (done && avs_write && ram_int) begin
      if (avs_byteenable[0]) begin
        ram_q[{ram_idx[8:1], 1'b1}] <= avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        ram_q[{ram_idx[8:1], 1'b0}] <= avs_writedata[15:8];
      end
    end
  end

  // PROM write on chip enable falling edge
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prom_ce_n_d1_q <= 1'b1;
    end else begin
      prom_ce_n_d1_q <= prom_s.ce_n;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (prom_mode && prom_ce_n_d1_q && !prom_s.ce_n && prom_s.oe_n &&
        (prom_s.addr <= 15'(omsp_pkg::ROM_HI))) begin
      rom_q[prom_s.addr[13:0]] <= prom_s.data;
    end
  end

  // Verify data out
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      prom_do_q <= omsp_pkg::ERASED;
    end else if (prom_s.addr <= 15'(omsp_pkg::ROM_HI)) begin
      prom_do_q <= rom_q[prom_s.addr[13:0]];
    end else begin
      prom_do_q <= omsp_pkg::ERASED;
    end
  end

  assign prom_data_pins_o = prom_do_q;
  assign prom_data_pins_oe = {8{prom_mode && prom_s.ce_n && !prom_s.oe_n}};

  // Read data mux
  always_comb begin
    rd_d = 16'h0000;
    if (ram_int) begin
      rd_d = {ram_q[{ram_idx[8:1], 1'b0}], ram_q[{ram_idx[8:1], 1'b1}]};
    end else if (ram_blocked) begin
      rd_d = {omsp_pkg::ERASED, omsp_pkg::ERASED};
    end else if (rom_int) begin
      rd_d = {rom_q[{rom_idx[13:1], 1'b0}], rom_q[{rom_idx[13:1], 1'b1}]};
    end else if (in_ctrl) begin
      rd_d = {15'h0000, ram_on_q};
    end else if (in_mode) begin
      rd_d = {14'h0000, mode_q};
    end else begin
      rd_d = ext_readdata;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      avs_readdata <= 16'h0000;
    end else if (avs_read && !cpu_halt && (st_q == omsp_pkg::ACC_STATES - 2'h2)) begin
      avs_readdata <= rd_d;
    end
  end

  // Checks
  property p_ram_on_reset;
    @(posedge clk_sys) $rose(nrst) |-> ram_on_q;
  endproperty
  a_ram_on_reset: assert property (p_ram_on_reset) else $error("ram on bit not set");

  property p_two_states;
    @(posedge clk_sys) disable iff (!nrst)
      ((avs_read || avs_write) && !cpu_halt && !busy_q) |=> !avs_waitrequest;
  endproperty
  a_two_states: assert property (p_two_states) else $error("access not two states");

  property p_blocked_ff;
    @(posedge clk_sys) disable iff (!nrst)
      (avs_read && ram_blocked && !busy_q && !cpu_halt) |=> (avs_readdata == 16'hffff);
  endproperty
  a_blocked_ff: assert property (p_blocked_ff) else $error("blocked read not ff");

  property p_ext_off;
    @(posedge clk_sys) disable iff (!nrst) (ram_on_q && in_ram) |-> !ext_req;
  endproperty
  a_ext_off: assert property (p_ext_off) else $error("ram window went outside");

  property p_ext_on;
    @(posedge clk_sys) disable iff (!nrst)
      (avs_read && in_ram && !ram_on_q && !cpu_halt &&
       mode_q != omsp_pkg::OMSP_MODE_3) |-> ext_req;
  endproperty
  a_ext_on: assert property (p_ext_on) else $error("ram window not outside");

  property p_rom_mode1;
    @(posedge clk_sys) disable iff (!nrst)
      (caught_q && mode_q == omsp_pkg::OMSP_MODE_1) |-> !rom_enabled;
  endproperty
  a_rom_mode1: assert property (p_rom_mode1) else $error("rom on in mode 1");

  property p_mode_stable;
    @(posedge clk_sys) disable iff (!nrst) $past(caught_q) |-> $stable(mode_q);
  endproperty
  a_mode_stable: assert property (p_mode_stable) else $error("mode changed");

  property p_float;
    @(posedge clk_sys) disable iff (!nrst)
      (prom_s.oe_n || !prom_s.ce_n) |-> (prom_data_pins_oe == 8'h00);
  endproperty
  a_float: assert property (p_float) else $error("data driven outside verify");

  property p_halt_wait;
    @(posedge clk_sys) disable iff (!nrst) (cpu_halt && !busy_q) |-> avs_waitrequest;
  endproperty
  a_halt_wait: assert property (p_halt_wait) else $error("bus answered in prom mode");

  property p_halt_no_ext;
    @(posedge clk_sys) disable iff (!nrst) cpu_halt |-> !ext_req;
  endproperty
  a_halt_no_ext: assert property (p_halt_no_ext) else $error("outside access in prom mode");

  property p_ext_addr;
    @(posedge clk_sys) disable iff (!nrst) ext_req |-> (ext_address == avs_address);
  endproperty
  a_ext_addr: assert property (p_ext_addr) else $error("outside address wrong");

  property p_ext_idle;
    @(posedge clk_sys) disable iff (!nrst) !(avs_read || avs_write) |-> !ext_req;
  endproperty
  a_ext_idle: assert property (p_ext_idle) else $error("outside request while idle");

  property p_blocked_no_ext;
    @(posedge clk_sys) disable iff (!nrst)
      (in_ram && !ram_on_q && mode_q == omsp_pkg::OMSP_MODE_3) |-> !ext_req;
  endproperty
  a_blocked_no_ext: assert property (p_blocked_no_ext) else $error("blocked window outside");

  property p_rom_off_ext;
    @(posedge clk_sys) disable iff (!nrst)
      (avs_read && in_rom && !rom_enabled && !cpu_halt) |-> ext_req;
  endproperty
  a_rom_off_ext: assert property (p_rom_off_ext) else $error("rom area not outside");

  property p_rom_on_int;
    @(posedge clk_sys) disable iff (!nrst) (in_rom && rom_enabled) |-> !ext_req;
  endproperty
  a_rom_on_int: assert property (p_rom_on_int) else $error("rom area went outside");

  property p_done_busy;
    @(posedge clk_sys) disable iff (!nrst) !avs_waitrequest |-> busy_q;
  endproperty
  a_done_busy: assert property (p_done_busy) else $error("answer without request");

  property p_done_once;
    @(posedge clk_sys) disable iff (!nrst) !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_done_once: assert property (p_done_once) else $error("answer held too long");

  property p_standby_hold;
    @(posedge clk_sys) disable iff (!nrst) sw_standby |=> $stable(internal_ram_on_bit);
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("ram on bit moved in standby");

  property p_ram_on_idle;
    @(posedge clk_sys) disable iff (!nrst)
      !(avs_write && in_ctrl) |=> $stable(internal_ram_on_bit);
  endproperty
  a_ram_on_idle: assert property (p_ram_on_idle) else $error("ram on bit moved alone");

  property p_mode_read;
    @(posedge clk_sys) disable iff (!nrst)
      (caught_q && avs_read && in_mode && !busy_q && !cpu_halt) |=> (avs_readdata[1:0] == mode_q);
  endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

  property p_ctrl_read;
    @(posedge clk_sys) disable iff (!nrst)
      (avs_read && in_ctrl && !busy_q && !cpu_halt) |=> (avs_readdata == {15'h0000, ram_on_q});
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

  property p_readdata_hold;
    @(posedge clk_sys) disable iff (!nrst)
      !(avs_read && !busy_q && !cpu_halt) |=> $stable(avs_readdata);
  endproperty
  a_readdata_hold: assert property (p_readdata_hold) else $error("read data not held");

  property p_ext_read_data;
    @(posedge clk_sys) disable iff (!nrst)
      (avs_read && ext_req && !busy_q) |=> (avs_readdata == $past(ext_readdata));
  endproperty
  a_ext_read_data: assert property (p_ext_read_data) else $error("outside data lost");

  property p_prom_oe_verify;
    @(posedge clk_sys) disable iff (!nrst)
      (prom_mode && prom_s.ce_n && !prom_s.oe_n) |-> (prom_data_pins_oe == 8'hff);
  endproperty
  a_prom_oe_verify: assert property (p_prom_oe_verify) else $error("verify not driven");

  property p_prom_high_ff;
    @(posedge clk_sys) disable iff (!nrst)
      (prom_s.addr > 15'(omsp_pkg::ROM_HI)) |=> (prom_data_pins_o == omsp_pkg::ERASED);
  endproperty
  a_prom_high_ff: assert property (p_prom_high_ff) else $error("beyond rom not all ones");

  property p_rom_mode23;
    @(posedge clk_sys) disable iff (!nrst)
      (mode_q == omsp_pkg::OMSP_MODE_2 || mode_q == omsp_pkg::OMSP_MODE_3) |-> rom_enabled;
  endproperty
  a_rom_mode23: assert property (p_rom_mode23) else $error("rom off in mode 2 or 3");

  property p_caught_stays;
    @(posedge clk_sys) disable iff (!nrst) caught_q |=> caught_q;
  endproperty
  a_caught_stays: assert property (p_caught_stays) else $error("mode caught twice");

  property p_capture;
    @(posedge clk_sys) disable iff (!nrst)
      $rose(caught_q) |-> (mode_q == omsp_pkg::omsp_mode_t'($past({md1_s, md0_s})));
  endproperty
  a_capture: assert property (p_capture) else $error("mode not from pins");
endmodule // omsp_mem_select

// File: verilog/omsp_pkg.sv
// What this block does
// - In expanded modes with the RAM on bit set, the RAM window goes to internal RAM.
// - In expanded modes with the RAM on bit clear, the RAM window goes to the external bus.
// - In single-chip mode with the RAM on bit set, the RAM window goes to internal RAM.
// - In single-chip mode with the RAM on bit clear, writes to the RAM window are dropped.
// - In single-chip mode with the RAM on bit clear, reads of the RAM window return all ones.
// - A 16K-byte ROM sits on a 16-bit path and completes byte and word accesses in two states.
// - The mode is caught from the two mode pins on leaving reset and decides ROM enable.
// - Mode 1 disables the ROM and maps it outside; modes 2 and 3 enable it.
// - Both mode pins and standby low with both select pins high enter PROM mode and halt the CPU.
// - PROM pins: chip enable low writes, output enable low verifies, both high floats the data.
// - The RAM on bit is one after reset and keeps its value through software standby.
package omsp_pkg;
  localparam logic [15:0] RAM_LO = 16'hfd80;
  localparam logic [15:0] RAM_HI = 16'hff7f;
  localparam logic [15:0] ROM_HI = 16'h3fff;
  localparam int ROM_BYTES = 16384;
  localparam int RAM_BYTES = 512;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [15:0] CTRL_OFS = 16'hffc4;
  localparam logic [15:0] MODE_OFS = 16'hffc6;
  localparam logic RAM_ON_RST = 1'b1;
  localparam logic [1:0] ACC_STATES = 2'h2;

  typedef enum logic [1:0] {
    OMSP_MODE_PROM,
    OMSP_MODE_1,
    OMSP_MODE_2,
    OMSP_MODE_3
  } omsp_mode_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic [14:0] addr;
    logic [7:0] data;
  } omsp_prom_in_t;
endpackage

// File: verilog/omsp_sync.sv
`timescale 1ns/1ns
module omsp_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      meta_q <= '0;
      q <= '0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule // omsp_sync
